// [core/msclk_consts.svh]
// Offsets, field positions, reset values and timing counts of the clock generator.
// Assumes a 40 MHz mclk and an 8-bit register port with a 3-bit word index.
`ifndef MSCLK_CONSTS_SVH
`define MSCLK_CONSTS_SVH
`define MSCLK_A_CTRL1 3'h0
`define MSCLK_A_CTRL2 3'h1
`define MSCLK_A_TRIM 3'h2
`define MSCLK_A_CTRL3 3'h3
`define MSCLK_A_STATUS 3'h4
`define MSCLK_A_CAUSE 3'h5
`define MSCLK_CTRL1_RST 8'h04
`define MSCLK_CTRL2_RST 8'h00
`define MSCLK_TRIM_RST 8'h80
`define MSCLK_CTRL3_RST 8'h00
`define MSCLK_B_IRSTOP 0
`define MSCLK_B_IROE 1
`define MSCLK_B_IRSEL 2
`define MSCLK_B_ERSTOP 1
`define MSCLK_B_LPD 2
`define MSCLK_B_EROE 3
`define MSCLK_B_RANGE 5
`define MSCLK_B_FINE 0
`define MSCLK_B_PLLSEL 1
`define MSCLK_B_CME 5
`define MSCLK_B_LOCKIE 7
`define MSCLK_B_LOCKF 7
`define MSCLK_B_LOC 0
`define MSCLK_IRC_HALF_BASE 10'h040
`define MSCLK_CLK_MHZ 40
`define MSCLK_LOC_HIGH_NS 4000
`define MSCLK_LOC_LOW_NS 40000
`define MSCLK_LOC_HIGH_CYC ((`MSCLK_LOC_HIGH_NS * `MSCLK_CLK_MHZ) / 1000)
`define MSCLK_LOC_LOW_CYC ((`MSCLK_LOC_LOW_NS * `MSCLK_CLK_MHZ) / 1000)
`endif

// [core/msclk_pkg.sv]
// Types shared by the clock generator.
// Assumes nothing beyond a SystemVerilog compiler.
package msclk_pkg;
	typedef enum logic [2:0] {
		MSCLK_SRC_LOOP = 3'b001,
		MSCLK_SRC_IRC = 3'b010,
		MSCLK_SRC_EXT = 3'b100
	} msclk_src_t;
endpackage

// [core/msclk_gen.sv]
// Clock generator control: source mux, bus divider, debug clock, references, monitor.
// Assumes mclk_i at 40 MHz; loop and external clocks arrive on pins much slower than mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "msclk_consts.svh"
module msclk_gen
	import msclk_pkg::*;
(
	input wire logic mclk_i, // System clock, 40 MHz.
	input wire logic rst_b_i, // Power-on reset, active low.
	input wire logic soft_rst_i, // Any other reset source, synchronous.
	input wire logic [2:0] addr_i, // Register index.
	input wire logic [7:0] wdata_i, // Write data.
	input wire logic wr_i, // Write strobe.
	input wire logic rd_i, // Read strobe.
	input wire logic stop_i, // Stop mode request.
	input wire logic ext_ref_i, // External reference clock pin.
	input wire logic fll_clk_i, // FLL oscillator output.
	input wire logic pll_clk_i, // PLL oscillator output.
	input wire logic pll_lock_i, // PLL lock indication.
	output logic [7:0] rdata_o, // Read data, cycle after read strobe.
	output logic main_clk_o, // Main generator output.
	output logic bus_clk_o, // Divided bus clock.
	output logic dbg_clk_o, // Debug half rate clock.
	output logic irc_aux_o, // Internal reference auxiliary clock.
	output logic ext_aux_o, // External reference auxiliary clock.
	output logic loop_ref_o, // Reference fed to the loops.
	output logic fll_en_o, // FLL enable.
	output logic pll_en_o, // PLL enable.
	output logic ext_osc_en_o, // External oscillator keep-running.
	output logic chip_rst_o, // Chip reset request on clock loss.
	output logic lock_irq_o // Lock interrupt request.
);
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] trim_q;
	logic fine_q;
	logic [7:0] ctrl3_q;
	logic [7:0] rdata_q;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] pin_q;
	logic [9:0] irc_cnt_q;
	logic irc_q;
	logic [9:0] irc_half;
	logic irc_run;
	logic [1:0] clks;
	logic internal_ref_select;
	logic lpd;
	logic pll_sel;
	logic ext_mode;
	logic digital_oscillator;
	logic pll_use_q;
	logic dco_d1_q;
	logic dbg_q;
	msclk_src_t sel_q;
	msclk_src_t req;
	logic req_lvl;
	logic cur_lvl;
	logic mux_q;
	logic mux_d1_q;
	logic [2:0] div_q;
	logic bus_q;
	logic ext_d1_q;
	logic [11:0] loc_cnt_q;
	logic [11:0] loc_lim;
	logic loc_q;
	logic loc_hit;
	logic rst_req_q;
	logic lock_d1_q;
	logic lock_flag_q;
	logic irq_q;
	logic [5:0] aux_q;
	logic wr_lockf;

	// Pins pass three flops; the filtered copy moves only when the second and third agree.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge mclk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= gi == 0 ? ext_ref_i : gi == 1 ? fll_clk_i :
						gi == 2 ? pll_clk_i : pll_lock_i;
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						pin_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign clks = ctrl1_q[7:6];
	assign internal_ref_select = ctrl1_q[`MSCLK_B_IRSEL];
	assign lpd = ctrl2_q[`MSCLK_B_LPD];
	assign pll_sel = ctrl3_q[`MSCLK_B_PLLSEL];
	// External reference is in use by the loops or selected directly.
	assign ext_mode = (clks == 2'b10) || (!internal_ref_select && !lpd) || (!internal_ref_select && clks == 2'b00);
	assign digital_oscillator = pll_use_q ? pin_q[2] : pin_q[1];
	assign wr_lockf = wr_i && addr_i == `MSCLK_A_STATUS && wdata_i[`MSCLK_B_LOCKF];

	// Control registers; the period adjust survives every reset but power-on.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trim_q <= `MSCLK_TRIM_RST;
			fine_q <= 1'b0;
		end else if (wr_i && addr_i == `MSCLK_A_TRIM) begin
			trim_q <= wdata_i;
		end else if (wr_i && addr_i == `MSCLK_A_CTRL3) begin
			fine_q <= wdata_i[`MSCLK_B_FINE];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl1_q <= `MSCLK_CTRL1_RST;
			ctrl2_q <= `MSCLK_CTRL2_RST;
			ctrl3_q <= `MSCLK_CTRL3_RST;
		end else if (soft_rst_i) begin
			ctrl1_q <= `MSCLK_CTRL1_RST;
			ctrl2_q <= `MSCLK_CTRL2_RST;
			ctrl3_q <= `MSCLK_CTRL3_RST;
		end else if (wr_i) begin
			case (addr_i)
				`MSCLK_A_CTRL1: begin
					ctrl1_q <= wdata_i;
				end
				`MSCLK_A_CTRL2: begin
					ctrl2_q <= wdata_i;
				end
				`MSCLK_A_CTRL3: begin
					ctrl3_q <= wdata_i;
				end
				default: begin
					ctrl1_q <= ctrl1_q;
				end
			endcase
		end
	end

	// Internal reference: half period grows with the nine-bit adjust value.
	assign irc_half = `MSCLK_IRC_HALF_BASE + {1'b0, trim_q, fine_q};
	// Runs unless stopped, or in stop when both keep and output enable are set.
	assign irc_run = !stop_i || (ctrl1_q[`MSCLK_B_IRSTOP] && ctrl1_q[`MSCLK_B_IROE]);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irc_cnt_q <= 10'h000;
			irc_q <= 1'b0;
		end else if (!irc_run) begin
			irc_cnt_q <= 10'h000;
		end else if (irc_cnt_q >= irc_half - 10'h001) begin
			irc_cnt_q <= 10'h000;
			irc_q <= ~irc_q;
		end else begin
			irc_cnt_q <= irc_cnt_q + 10'h001;
		end
	end

	// Source request from the select field; the loops take either reference.
	always_comb begin
		case (clks)
			2'b01: begin
				req = MSCLK_SRC_IRC;
			end
			2'b10: begin
				req = MSCLK_SRC_EXT;
			end
			default: begin
				req = MSCLK_SRC_LOOP;
			end
		endcase
		case (req)
			MSCLK_SRC_IRC: begin
				req_lvl = irc_q;
			end
			MSCLK_SRC_EXT: begin
				req_lvl = pin_q[0];
			end
			default: begin
				req_lvl = digital_oscillator;
			end
		endcase
		case (sel_q)
			MSCLK_SRC_IRC: begin
				cur_lvl = irc_q;
			end
			MSCLK_SRC_EXT: begin
				cur_lvl = pin_q[0];
			end
			default: begin
				cur_lvl = digital_oscillator;
			end
		endcase
	end

	// Switch only while old and new sources are both low, so no phase is cut short.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sel_q <= MSCLK_SRC_LOOP;
			mux_q <= 1'b0;
			mux_d1_q <= 1'b0;
		end else begin
			if (req != sel_q && !cur_lvl && !req_lvl) begin
				sel_q <= req;
			end
			mux_q <= stop_i ? 1'b0 : cur_lvl;
			mux_d1_q <= mux_q;
		end
	end

	// Bus divider counts source rising edges; the ratio select is used straight away.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= 3'h0;
			bus_q <= 1'b0;
		end else begin
			if (mux_q && !mux_d1_q) begin
				div_q <= div_q + 3'h1;
			end
			case (ctrl2_q[7:6])
				2'b00: begin
					bus_q <= mux_q;
				end
				2'b01: begin
					bus_q <= div_q[0];
				end
				2'b10: begin
					bus_q <= div_q[1];
				end
				default: begin
					bus_q <= div_q[2];
				end
			endcase
		end
	end

	// Oscillator choice follows the PLL select only while both loops are low.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pll_use_q <= 1'b0;
		end else if (pll_sel != pll_use_q && !pin_q[1] && !pin_q[2]) begin
			pll_use_q <= pll_sel;
		end
	end

	// Debug clock toggles on each oscillator rising edge, in FLL and PLL alike.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dco_d1_q <= 1'b0;
			dbg_q <= 1'b0;
		end else begin
			dco_d1_q <= digital_oscillator;
			if (digital_oscillator && !dco_d1_q) begin
				dbg_q <= ~dbg_q;
			end
		end
	end

	// Clock monitor: too long without an external edge means the reference is lost.
	assign loc_lim = ctrl2_q[`MSCLK_B_RANGE] ? 12'(`MSCLK_LOC_HIGH_CYC) :
		12'(`MSCLK_LOC_LOW_CYC);
	// A loss event in this cycle; it wins over a clear of the flag in the same cycle.
	assign loc_hit = ctrl3_q[`MSCLK_B_CME] && !(pin_q[0] && !ext_d1_q) && !soft_rst_i &&
		loc_cnt_q >= loc_lim;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_d1_q <= 1'b0;
			loc_cnt_q <= 12'h000;
			loc_q <= 1'b0;
			rst_req_q <= 1'b0;
		end else begin
			ext_d1_q <= pin_q[0];
			rst_req_q <= 1'b0;
			if (!ctrl3_q[`MSCLK_B_CME] || (pin_q[0] && !ext_d1_q) || soft_rst_i) begin
				loc_cnt_q <= 12'h000;
			end else if (loc_cnt_q >= loc_lim) begin
				loc_cnt_q <= 12'h000;
				loc_q <= 1'b1;
				rst_req_q <= 1'b1;
			end else begin
				loc_cnt_q <= loc_cnt_q + 12'h001;
			end
			if (wr_i && addr_i == `MSCLK_A_CAUSE && wdata_i[`MSCLK_B_LOC] && !loc_hit) begin
				loc_q <= 1'b0;
			end
		end
	end

	// Lock detector: rising lock sets a sticky flag; a new event wins over a clear.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_d1_q <= 1'b0;
			lock_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			lock_d1_q <= pin_q[3];
			if (pin_q[3] && !lock_d1_q) begin
				lock_flag_q <= 1'b1;
			end else if (wr_lockf || soft_rst_i) begin
				lock_flag_q <= 1'b0;
			end
			irq_q <= lock_flag_q && ctrl3_q[`MSCLK_B_LOCKIE];
		end
	end

	// Auxiliary outputs, loop enables and loop reference.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aux_q <= 6'h00;
		end else begin
			aux_q[0] <= ctrl1_q[`MSCLK_B_IROE] && irc_run && irc_q;
			aux_q[1] <= ctrl2_q[`MSCLK_B_EROE] && pin_q[0];
			aux_q[2] <= internal_ref_select ? irc_q : pin_q[0];
			aux_q[3] <= !stop_i && !pll_sel && (clks == 2'b00 || !lpd);
			aux_q[4] <= !stop_i && pll_sel && (clks == 2'b00 || !lpd);
			aux_q[5] <= !stop_i || ext_mode ||
				(ctrl2_q[`MSCLK_B_ERSTOP] && ctrl2_q[`MSCLK_B_EROE]);
		end
	end

	// Register read port, data one cycle after the strobe.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`MSCLK_A_CTRL1: begin
					rdata_q <= ctrl1_q;
				end
				`MSCLK_A_CTRL2: begin
					rdata_q <= ctrl2_q;
				end
				`MSCLK_A_TRIM: begin
					rdata_q <= trim_q;
				end
				`MSCLK_A_CTRL3: begin
					rdata_q <= {ctrl3_q[7:1], fine_q};
				end
				`MSCLK_A_STATUS: begin
					rdata_q <= {lock_flag_q, pin_q[3], 1'b0, sel_q, 1'b0, internal_ref_select};
				end
				`MSCLK_A_CAUSE: begin
					rdata_q <= {7'h00, loc_q};
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o = rdata_q;
	assign main_clk_o = mux_q;
	assign bus_clk_o = bus_q;
	assign dbg_clk_o = dbg_q;
	assign irc_aux_o = aux_q[0];
	assign ext_aux_o = aux_q[1];
	assign loop_ref_o = aux_q[2];
	assign fll_en_o = aux_q[3];
	assign pll_en_o = aux_q[4];
	assign ext_osc_en_o = aux_q[5];
	assign chip_rst_o = rst_req_q;
	assign lock_irq_o = irq_q;
endmodule
`default_nettype wire

// [test/msclk_gen_checker.sv]
// Port assertions for the clock generator, bound into msclk_gen.
// Assumes registers change only through the write strobe and the two resets.
`timescale 1ns/1ps
`default_nettype none
module msclk_gen_checker (
	input wire logic mclk_i, // Clock.
	input wire logic rst_b_i, // Reset.
	input wire logic soft_rst_i, // Soft reset.
	input wire logic [2:0] addr_i, // Index.
	input wire logic [7:0] wdata_i, // Data.
	input wire logic wr_i, // Write.
	input wire logic stop_i, // Stop.
	input wire logic ext_ref_i, // Ext pin.
	input wire logic irc_aux_o, // Irc out.
	input wire logic ext_aux_o, // Ext out.
	input wire logic loop_ref_o, // Loop ref.
	input wire logic chip_rst_o, // Loss reset.
	input wire logic lock_irq_o // Lock irq.
);
	logic [7:0] c1_q, c2_q, c3_q;
	logic ext_q;
	int gap_q;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c1_q <= 8'h04;
			c2_q <= 8'h00;
			c3_q <= 8'h00;
		end else if (soft_rst_i) begin
			c1_q <= 8'h04;
			c2_q <= 8'h00;
			c3_q <= 8'h00;
		end else if (wr_i && addr_i == 3'h0) begin
			c1_q <= wdata_i;
		end else if (wr_i && addr_i == 3'h1) begin
			c2_q <= wdata_i;
		end else if (wr_i && addr_i == 3'h3) begin
			c3_q <= wdata_i;
		end
	end
	// Cycles since the last raw rise of the external pin.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_q <= 1'b0;
			gap_q <= 0;
		end else begin
			ext_q <= ext_ref_i;
			gap_q <= (ext_ref_i && !ext_q) ? 0 : gap_q + 1;
		end
	end
	irc_off_a: assert property (!c1_q[1] [*3] |-> !irc_aux_o)
		else $error("internal aux runs while disabled");
	irc_stop_a: assert property ((stop_i && !(c1_q[0] && c1_q[1])) [*4] |-> !irc_aux_o)
		else $error("internal aux runs in stop");
	ext_off_a: assert property (!c2_q[3] [*3] |-> !ext_aux_o)
		else $error("external aux runs while disabled");
	ext_follow_a: assert property ((c2_q[3] && !stop_i && $stable(ext_ref_i)) [*7]
		|-> ext_aux_o == ext_ref_i)
		else $error("external aux does not follow pin");
	loop_ext_a: assert property ((!c1_q[2] && !stop_i && $stable(ext_ref_i)) [*7]
		|-> loop_ref_o == ext_ref_i)
		else $error("loop reference is not the external pin");
	rst_pulse_a: assert property (chip_rst_o |=> !chip_rst_o)
		else $error("loss reset longer than one cycle");
	rst_armed_a: assert property (chip_rst_o |-> $past(c3_q[5]))
		else $error("loss reset while monitor disarmed");
	loss_gap_a: assert property (chip_rst_o |-> gap_q >= (c2_q[5] ? 150 : 1590))
		else $error("loss reset before threshold");
	lock_irq_a: assert property (lock_irq_o |-> $past(c3_q[7]))
		else $error("lock request while disabled");
	cover property (chip_rst_o);
	cover property (lock_irq_o);
	cover property (ext_aux_o && c2_q[3]);
endmodule
bind msclk_gen msclk_gen_checker chk_i (.mclk_i, .rst_b_i, .soft_rst_i, .addr_i, .wdata_i,
	.wr_i, .stop_i, .ext_ref_i, .irc_aux_o, .ext_aux_o, .loop_ref_o, .chip_rst_o, .lock_irq_o);
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the clock generator.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_i, rst_b_i, soft_rst_i, wr_i, rd_i, stop_i;
	logic ext_ref_i = 1'b0, fll_clk_i = 1'b0, pll_clk_i = 1'b0, rd_p = 1'b0;
	logic pll_lock_i, main_clk_o, bus_clk_o, dbg_clk_o, irc_aux_o, ext_aux_o, loop_ref_o;
	logic fll_en_o, pll_en_o, ext_osc_en_o, chip_rst_o, lock_irq_o, ext_run;
	logic [2:0] addr_i;
	logic [7:0] wdata_i, rdata_o, v;
	logic [7:0] q[$];
	logic [4:0] s, p;
	int mismatches, comparisons, seed, n, c[5];
	int ph = 0;
	msclk_gen DUT (.mclk_i, .rst_b_i, .soft_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .stop_i,
		.ext_ref_i, .fll_clk_i, .pll_clk_i, .pll_lock_i, .rdata_o, .main_clk_o, .bus_clk_o,
		.dbg_clk_o, .irc_aux_o, .ext_aux_o, .loop_ref_o, .fll_en_o, .pll_en_o, .ext_osc_en_o,
		.chip_rst_o, .lock_irq_o);
	task chkn(input string nm, input int e, input int g, input int t);
		comparisons++;
		if (g < e - t || g > e + t) begin
			mismatches++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		rd_i <= 1'b1;
		addr_i <= a;
		q.push_back(e);
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	// Counts rising edges of main, bus, debug, internal aux and external aux.
	task cnt(input int m);
		c = '{default: 0};
		p = {main_clk_o, bus_clk_o, dbg_clk_o, irc_aux_o, ext_aux_o};
		repeat (m) begin
			@(posedge mclk_i);
			s = {main_clk_o, bus_clk_o, dbg_clk_o, irc_aux_o, ext_aux_o};
			for (int i = 0; i < 5; i++) if (s[i] && !p[i]) c[i]++;
			p = s;
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Loop oscillators at 16 and 10 cycles, external reference at 24 cycles.
	always @(posedge mclk_i) begin
		ph <= ph + 1;
		if (ph % 8 == 7) fll_clk_i <= ~fll_clk_i;
		if (ph % 5 == 4) pll_clk_i <= ~pll_clk_i;
		if (ext_run && ph % 12 == 11) ext_ref_i <= ~ext_ref_i;
	end
	always @(posedge mclk_i) begin
		if (rd_p) chk8("rdata", q.pop_front(), rdata_o);
		rd_p <= rd_i;
	end
	initial begin
		repeat (60000) @(posedge mclk_i);
		mismatches++;
		report_and_stop;
	end
	initial begin
		{rst_b_i, soft_rst_i, wr_i, rd_i, stop_i} = 5'h00;
		{pll_lock_i, ext_run, addr_i, wdata_i} = 13'h0000;
		seed = 28;
		repeat (6) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		rd(3'h0, 8'h04);
		rd(3'h2, 8'h80);
		rd(3'h7, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(3'h2, v);
			rd(3'h2, v);
		end
		wr(3'h0, 8'h06);
		soft_rst_i <= 1'b1;
		@(posedge mclk_i);
		soft_rst_i <= 1'b0;
		@(posedge mclk_i);
		rd(3'h2, v);
		rd(3'h0, 8'h04);
		rst_b_i <= 1'b0;
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		rd(3'h2, 8'h80);
		$display("reset test done");
		chk8("fll_en", 8'h01, {7'h00, fll_en_o});
		for (int d = 0; d < 4; d++) begin
			wr(3'h1, 8'(d << 6));
			cnt(1024);
			chkn("bus", 64 >> d, c[3], 1);
			chkn("dbg", 32, c[2], 1);
		end
		wr(3'h3, 8'h02);
		cnt(1000);
		chkn("dbg", 50, c[2], 1);
		chk8("pll_en", 8'h01, {7'h00, pll_en_o});
		wr(3'h3, 8'h00);
		$display("divider test done");
		wr(3'h2, 8'h00);
		wr(3'h0, 8'h46);
		wr(3'h1, 8'h04);
		repeat (200) @(posedge mclk_i);
		chk8("fll_en", 8'h00, {7'h00, fll_en_o});
		for (int t = 0; t < 2; t++) begin
			wr(3'h2, t ? 8'h40 : 8'h00);
			cnt(3840);
			chkn("irc", t ? 10 : 30, c[1], 1);
			chkn("main", t ? 10 : 30, c[4], 1);
		end
		wr(3'h0, 8'h47);
		stop_i <= 1'b1;
		cnt(1280);
		chkn("irc", 3, c[1], 1);
		wr(3'h0, 8'h46);
		cnt(512);
		chkn("irc", 0, c[1], 0);
		stop_i <= 1'b0;
		$display("internal test done");
		ext_run <= 1'b1;
		wr(3'h1, 8'h08);
		wr(3'h0, 8'h80);
		repeat (400) @(posedge mclk_i);
		cnt(1200);
		chkn("ext", 50, c[0], 1);
		chkn("main", 50, c[4], 1);
		wr(3'h1, 8'h0A);
		stop_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk8("osc_en", 8'h01, {7'h00, ext_osc_en_o});
		stop_i <= 1'b0;
		$display("external test done");
		for (int r = 1; r >= 0; r--) begin
			ext_run <= 1'b0;
			wr(3'h1, r ? 8'h20 : 8'h00);
			wr(3'h3, 8'h20);
			n = 0;
			while (chip_rst_o !== 1'b1 && n < 3000) begin
				@(posedge mclk_i);
				n++;
			end
			chkn("loss", r ? 160 : 1600, n, 30);
			rd(3'h5, 8'h01);
			wr(3'h3, 8'h00);
			wr(3'h5, 8'h01);
			rd(3'h5, 8'h00);
		end
		ext_run <= 1'b1;
		$display("monitor test done");
		wr(3'h3, 8'h80);
		pll_lock_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk8("irq", 8'h01, {7'h00, lock_irq_o});
		rd(3'h4, 8'hD0);
		wr(3'h4, 8'h80);
		repeat (3) @(posedge mclk_i);
		chk8("irq", 8'h00, {7'h00, lock_irq_o});
		$display("lock test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
